/* File: inc/card_power_pkg.sv */
package card_power_pkg;

  localparam int WORD_W = 11;

  // Bit positions in the latched control word
  localparam int BIT_A_PROG_LO  = 0;
  localparam int BIT_A_PROG_HI  = 1;
  localparam int BIT_A_CORE_LO  = 2;
  localparam int BIT_A_CORE_HI  = 3;
  localparam int BIT_B_PROG_LO  = 4;
  localparam int BIT_B_PROG_HI  = 5;
  localparam int BIT_B_CORE_HI  = 6;
  localparam int BIT_B_CORE_LO  = 7;
  localparam int BIT_OUT_ENABLE = 8;
  localparam int BIT_A_PROG_5V  = 9;
  localparam int BIT_B_PROG_5V  = 10;

  localparam logic [10:0] WORD_RESET = 11'h000;

  // Break-before-make gap, set in ns and rounded up to sys_clk cycles
  localparam int BBM_GAP_NS     = 100;
  localparam int CLK_PERIOD_NS  = 4;
  localparam int BBM_GAP_CYCLES = (BBM_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Supply source select, one-hot free encoding
  typedef enum logic [2:0] {
    SRC_HIZ  = 3'h0,
    SRC_GND  = 3'h1,
    SRC_3V3  = 3'h2,
    SRC_5V   = 3'h3,
    SRC_12V  = 3'h4
  } src_e;

  localparam logic [2:0] SRC_RESET = 3'h1;

  typedef struct packed {
    src_e a_core;
    src_e a_prog;
    src_e b_core;
    src_e b_prog;
  } supply_sel_s;

  localparam logic [11:0] SEL_RESET = 12'h249;

  typedef struct packed {
    logic clk;
    logic data;
    logic latch;
  } serial_pins_s;

endpackage : card_power_pkg

/* File: design/supply_switch_seq.sv */
`timescale 1ns/1ps
// Break-before-make sequencer for one supply output
module supply_switch_seq #(
  parameter int GAP_CYCLES = card_power_pkg::BBM_GAP_CYCLES
) (
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire logic                 clk_en,
  input  wire card_power_pkg::src_e target,
  output card_power_pkg::src_e      drive
);

  typedef enum logic [1:0] {ST_HOLD, ST_OPEN} seq_e;

  seq_e                 state_q, state_d;
  card_power_pkg::src_e drive_q, drive_d;
  logic [7:0]           cnt_q, cnt_d;

  assign drive = drive_q;

  always_comb begin
    state_d = state_q;
    drive_d = drive_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_HOLD: begin
        if (target != drive_q) begin
          drive_d = card_power_pkg::SRC_HIZ; // RULE19
          cnt_d   = 8'(GAP_CYCLES);
          state_d = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (cnt_q > 8'h01) begin
          cnt_d = cnt_q - 8'h01;
        end else begin
          drive_d = target; // RULE19
          state_d = ST_HOLD;
        end
      end
      default: state_d = ST_HOLD;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= ST_HOLD;
      drive_q <= card_power_pkg::src_e'(card_power_pkg::SRC_RESET);
      cnt_q   <= 8'h00;
    end else if (clk_en) begin
      state_q <= state_d;
      drive_q <= drive_d;
      cnt_q   <= cnt_d;
    end
  end

endmodule : supply_switch_seq

/* File: design/card_power_serial_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) Shift data on each serial clock rise
// (RULE2) Latch rise loads the eleven shifted bits
// (RULE3) Controller latches before next clock rise
// (RULE4) Independent mode: slot A programming from D0,D1,D9
// (RULE5) Independent mode: slot B programming from D4,D5,D10
// (RULE6) Slot A core supply from D3,D2
// (RULE7) Slot B core supply from D6,D7
// (RULE8) D8 low floats all four outputs
// (RULE9) Coupled mode: programming 01 follows core
// (RULE10) Unconnected mode pin means coupled decoding
// (RULE11) Fault flag low on overcurrent or overtemperature
// (RULE12) Active-high reset input, weak pulldown
// (RULE13) Active-low reset input, weak pullup
// (RULE14) Standby request lowers every current limit
// (RULE15) Reset grounds outputs, blocks latching until relatched
// (RULE16) Power-up enters grounded reset state
// (RULE17) Controller sets outputs before entering standby
// (RULE18) Last bit shifted becomes D0
// (RULE19) Break before make on every switch
module card_power_serial_ctrl (
  input  wire logic                        sys_clk,
  input  wire logic                        srst,
  input  wire logic                        clk_en,
  input  wire card_power_pkg::serial_pins_s serial_pins,
  input  wire logic                        mode_independent,
  input  wire logic                        card_reset,
  input  wire logic                        card_reset_n,
  input  wire logic                        low_limit_request_n,
  input  wire logic                        overcurrent,
  input  wire logic                        overtemp,
  output card_power_pkg::supply_sel_s      supply_sel,
  output logic                             low_limit,
  output logic                             fault_flag_n
);

  // Two-stage synchronisers for every pin input
  logic [7:0] sync1_q, sync2_q;
  logic [7:0] pins_raw;

  assign pins_raw = {serial_pins.clk, serial_pins.data, serial_pins.latch, mode_independent,
                     card_reset, card_reset_n, low_limit_request_n, overcurrent | overtemp};

  // Reset to idle pin levels, so no false standby or mode follows reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync1_q <= 8'h06; // RULE10
      sync2_q <= 8'h06;
    end else if (clk_en) begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  logic s_clk, s_data, s_latch, s_mode, s_rst, s_rst_n, s_low_limit_request_n_n, s_fault;
  assign {s_clk, s_data, s_latch, s_mode, s_rst, s_rst_n, s_low_limit_request_n_n, s_fault} = sync2_q;

  // Edge detection and shift/latch state
  logic                       clk_prev_q, clk_prev_d;
  logic                       latch_prev_q, latch_prev_d;
  logic [10:0]                shift_q, shift_d;
  logic [10:0]                word_q, word_d;
  logic                       in_reset;

  // Pin pullups/pulldowns live in the pad ring; logic sees resolved levels
  assign in_reset = s_rst | ~s_rst_n; // RULE12 RULE13

  always_comb begin
    clk_prev_d   = s_clk;
    latch_prev_d = s_latch;
    shift_d      = shift_q;
    word_d       = word_q;
    if (s_clk && !clk_prev_q) begin
      shift_d = {shift_q[9:0], s_data}; // RULE1 RULE18
    end
    if (in_reset) begin
      word_d = card_power_pkg::WORD_RESET; // RULE15
    end else if (s_latch && !latch_prev_q) begin
      word_d = shift_q; // RULE2
    end
  end

  // Grounded state held until a fresh latch after reset
  logic grounded_q, grounded_d;

  always_comb begin
    grounded_d = grounded_q;
    if (in_reset) begin
      grounded_d = 1'b1; // RULE15
    end else if (s_latch && !latch_prev_q) begin
      grounded_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clk_prev_q   <= 1'b0;
      latch_prev_q <= 1'b0;
      shift_q      <= card_power_pkg::WORD_RESET;
      word_q       <= card_power_pkg::WORD_RESET;
      grounded_q   <= 1'b1; // RULE16
    end else if (clk_en) begin
      clk_prev_q   <= clk_prev_d;
      latch_prev_q <= latch_prev_d;
      shift_q      <= shift_d;
      word_q       <= word_d;
      grounded_q   <= grounded_d;
    end
  end

  // Decode
  function automatic card_power_pkg::src_e core_dec(input logic hi, input logic lo);
    case ({hi, lo})
      2'b01:   core_dec = card_power_pkg::SRC_3V3;
      2'b10:   core_dec = card_power_pkg::SRC_5V;
      default: core_dec = card_power_pkg::SRC_GND;
    endcase
  endfunction : core_dec

  function automatic card_power_pkg::src_e prog_dec(input logic b0, input logic b1,
                                                    input logic sel5, input logic indep,
                                                    input card_power_pkg::src_e core);
    case ({b0, b1})
      2'b00:   prog_dec = card_power_pkg::SRC_GND;
      2'b01:   prog_dec = indep ? (sel5 ? card_power_pkg::SRC_5V : card_power_pkg::SRC_3V3)
                                : core; // RULE9
      2'b10:   prog_dec = card_power_pkg::SRC_12V;
      default: prog_dec = card_power_pkg::SRC_HIZ;
    endcase
  endfunction : prog_dec

  card_power_pkg::supply_sel_s target;

  always_comb begin
    target.a_core = core_dec(word_q[card_power_pkg::BIT_A_CORE_HI],
                             word_q[card_power_pkg::BIT_A_CORE_LO]); // RULE6
    target.b_core = core_dec(word_q[card_power_pkg::BIT_B_CORE_HI],
                             word_q[card_power_pkg::BIT_B_CORE_LO]); // RULE7
    // Low mode level means coupled decoding
    target.a_prog = prog_dec(word_q[card_power_pkg::BIT_A_PROG_LO],
                             word_q[card_power_pkg::BIT_A_PROG_HI],
                             word_q[card_power_pkg::BIT_A_PROG_5V], s_mode,
                             target.a_core); // RULE4 RULE10
    target.b_prog = prog_dec(word_q[card_power_pkg::BIT_B_PROG_LO],
                             word_q[card_power_pkg::BIT_B_PROG_HI],
                             word_q[card_power_pkg::BIT_B_PROG_5V], s_mode,
                             target.b_core); // RULE5
    if (grounded_q) begin
      target = card_power_pkg::SEL_RESET; // RULE15
    end else if (!word_q[card_power_pkg::BIT_OUT_ENABLE]) begin
      target = '0; // RULE8
    end
  end

  // One sequencer per output
  card_power_pkg::src_e seq_out [4];
  card_power_pkg::src_e seq_tgt [4];
  assign seq_tgt[0] = target.a_core;
  assign seq_tgt[1] = target.a_prog;
  assign seq_tgt[2] = target.b_core;
  assign seq_tgt[3] = target.b_prog;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_seq
      supply_switch_seq u_seq (
        .sys_clk (sys_clk),
        .srst    (srst),
        .clk_en  (clk_en),
        .target  (seq_tgt[gi]),
        .drive   (seq_out[gi])
      );
    end
  endgenerate

  assign supply_sel = {seq_out[0], seq_out[1], seq_out[2], seq_out[3]};

  logic low_limit_q, fault_n_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      low_limit_q <= 1'b0;
      fault_n_q   <= 1'b1;
    end else if (clk_en) begin
      low_limit_q <= ~s_low_limit_request_n_n; // RULE14
      fault_n_q   <= ~s_fault; // RULE11
    end
  end

  assign low_limit    = low_limit_q;
  assign fault_flag_n = fault_n_q;

endmodule : card_power_serial_ctrl

/* File: verification/card_power_assertions.sv */
`timescale 1ns/1ps
module card_power_assertions (
  input wire logic                         sys_clk,
  input wire logic                         srst,
  input wire logic                         clk_en,
  input wire card_power_pkg::serial_pins_s serial_pins,
  input wire logic                         mode_independent,
  input wire logic                         card_reset,
  input wire logic                         card_reset_n,
  input wire logic                         low_limit_request_n,
  input wire logic                         overcurrent,
  input wire logic                         overtemp,
  input wire card_power_pkg::supply_sel_s  supply_sel,
  input wire logic                         low_limit,
  input wire logic                         fault_flag_n
);
  // Card resets ground outputs through the sequencers, yet switching checks pause then
  wire any_rst = srst || card_reset || !card_reset_n;
  default clocking @(posedge sys_clk); endclocking
  // A frozen clock enable stalls every path, so checks other than a_break_first and a_gap_held pause with it
  default disable iff (srst || !clk_en);
  a_fault_on_sense: assert property ((overcurrent || overtemp) |-> ##[1:4] !fault_flag_n)
    else $error("fault flag missed");
  a_fault_clears: assert property ((!(overcurrent || overtemp)) [*5] |-> fault_flag_n)
    else $error("fault flag stuck");
  a_limit_on_standby: assert property ((!low_limit_request_n) [*5] |-> low_limit)
    else $error("limit not reduced");
  a_limit_off_idle: assert property (low_limit_request_n [*5] |-> !low_limit)
    else $error("limit stuck reduced");
  a_high_reset_grounds: assert property ($rose(card_reset) |->
    ##[1:40] supply_sel == card_power_pkg::SEL_RESET) else $error("high reset not grounded");
  a_low_reset_grounds: assert property ($fell(card_reset_n) |->
    ##[1:40] supply_sel == card_power_pkg::SEL_RESET) else $error("low reset not grounded");
  a_por_grounds: assert property ($fell(srst) |->
    supply_sel == card_power_pkg::SEL_RESET) else $error("power-up not grounded");
  a_break_first: assert property (disable iff (any_rst) $changed(supply_sel.a_core) |->
    $past(supply_sel.a_core) == card_power_pkg::SRC_HIZ
    || supply_sel.a_core == card_power_pkg::SRC_HIZ) else $error("make before break");
  a_gap_held: assert property (disable iff (any_rst)
    $rose(supply_sel.b_prog == card_power_pkg::SRC_HIZ) |->
    (supply_sel.b_prog == card_power_pkg::SRC_HIZ) [*8]) else $error("gap too short");
  c_prog_12v: cover property (supply_sel.a_prog == card_power_pkg::SRC_12V);
  c_fault: cover property (!fault_flag_n);
  c_standby: cover property (low_limit);
endmodule : card_power_assertions

bind card_power_serial_ctrl card_power_assertions u_chk (
  .sys_clk             (sys_clk),
  .srst                (srst),
  .clk_en              (clk_en),
  .serial_pins         (serial_pins),
  .mode_independent    (mode_independent),
  .card_reset          (card_reset),
  .card_reset_n        (card_reset_n),
  .low_limit_request_n (low_limit_request_n),
  .overcurrent         (overcurrent),
  .overtemp            (overtemp),
  .supply_sel          (supply_sel),
  .low_limit           (low_limit),
  .fault_flag_n        (fault_flag_n)
);

/* File: verification/card_ctl_model.sv */
`timescale 1ns/1ps
module card_ctl_model (
  output card_power_pkg::serial_pins_s pins
);
  initial pins = '0;
  // Link clock idles low between frames; released data is inverted
  task automatic send(input logic [10:0] w);
    for (int i = 10; i >= 0; i--) begin
      pins.data = w[i];
      #16 pins.clk = 1'b1;
      #16 pins.clk = 1'b0;
    end
    #8 pins.latch = 1'b1;
    #16 pins.latch = 1'b0;
    pins.data = ~pins.data;
  endtask : send
endmodule : card_ctl_model

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
  logic sys_clk, srst, clk_en, mode_independent, card_reset, card_reset_n;
  logic low_limit_request_n, overcurrent, overtemp, low_limit, fault_flag_n;
  card_power_pkg::serial_pins_s serial_pins;
  card_power_pkg::supply_sel_s  supply_sel;
  int                           failures;
  int                           samples_checked;

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  card_ctl_model u_ctl (.pins(serial_pins));
  card_power_serial_ctrl u_dut (
    .sys_clk             (sys_clk),
    .srst                (srst),
    .clk_en              (clk_en),
    .serial_pins         (serial_pins),
    .mode_independent    (mode_independent),
    .card_reset          (card_reset),
    .card_reset_n        (card_reset_n),
    .low_limit_request_n (low_limit_request_n),
    .overcurrent         (overcurrent),
    .overtemp            (overtemp),
    .supply_sel          (supply_sel),
    .low_limit           (low_limit),
    .fault_flag_n        (fault_flag_n)
  );

  function automatic logic [2:0] prog(logic [1:0] p, logic v5, logic m, logic [2:0] c);
    case (p)
      2'h0: return 3'h1;
      2'h1: return m ? {2'h1, v5} : c;
      2'h2: return 3'h4;
      default: return 3'h0;
    endcase
  endfunction : prog

  function automatic logic [11:0] expect_sel(logic [10:0] w, logic m);
    logic [2:0] ac;
    logic [2:0] bc;
    ac = (w[3:2] == 2'h1) ? 3'h2 : (w[3:2] == 2'h2) ? 3'h3 : 3'h1;
    bc = ({w[6], w[7]} == 2'h1) ? 3'h2 : ({w[6], w[7]} == 2'h2) ? 3'h3 : 3'h1;
    if (!w[8]) return 12'h000;
    return {ac, prog({w[0], w[1]}, w[9], m, ac), bc, prog({w[4], w[5]}, w[10], m, bc)};
  endfunction : expect_sel

  task automatic chk(logic [11:0] got, logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic load(logic [10:0] w);
    u_ctl.send(w);
    repeat (32) @(negedge sys_clk);
  endtask : load

  task automatic t_decode(logic m);
    logic [10:0] w;
    mode_independent = m;
    for (int i = 0; i < 16; i++) begin
      w = {i[3], i[2], 1'b1, i[3:2], i[1:0], i[3:2], i[1:0]};
      load(w);
      chk(supply_sel, expect_sel(w, m));
    end
    load(11'h6FF);
    chk(supply_sel, expect_sel(11'h6FF, m));
    $display("decode mode %0d done", m);
  endtask : t_decode

  task automatic t_reset(logic hi);
    load(11'h1AA);
    card_reset = hi;
    card_reset_n = hi;
    repeat (40) @(negedge sys_clk);
    chk(supply_sel, card_power_pkg::SEL_RESET);
    load(11'h155);
    card_reset = 1'b0;
    card_reset_n = 1'b1;
    repeat (40) @(negedge sys_clk);
    chk(supply_sel, card_power_pkg::SEL_RESET);
    load(11'h155);
    chk(supply_sel, expect_sel(11'h155, mode_independent));
    $display("reset %0d done", hi);
  endtask : t_reset

  task automatic t_flags;
    // Outputs were settled by the last word, so standby is safe now
    low_limit_request_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk({11'h000, low_limit}, 12'h001);
    low_limit_request_n = 1'b1;
    overcurrent = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk({10'h000, low_limit, fault_flag_n}, 12'h000);
    overcurrent = 1'b0;
    overtemp = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk({11'h000, fault_flag_n}, 12'h000);
    overtemp = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk({11'h000, fault_flag_n}, 12'h001);
    $display("flags done");
  endtask : t_flags

  task automatic t_freeze;
    // A fault raised while frozen must stay hidden until state runs again
    clk_en = 1'b0;
    overtemp = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk({11'h000, fault_flag_n}, 12'h001);
    clk_en = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk({11'h000, fault_flag_n}, 12'h000);
    overtemp = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk({11'h000, fault_flag_n}, 12'h001);
    $display("freeze done");
  endtask : t_freeze

  task automatic tally_and_finish;
    $display("checked %0d mismatched %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  initial begin
    failures = 0;
    samples_checked = 0;
    {srst, clk_en, card_reset_n, low_limit_request_n} = 4'hF;
    {mode_independent, card_reset, overcurrent, overtemp} = 4'h0;
    repeat (8) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    chk(supply_sel, card_power_pkg::SEL_RESET);
    t_decode(1'b1);
    t_decode(1'b0);
    t_reset(1'b1);
    t_reset(1'b0);
    t_flags;
    t_freeze;
    tally_and_finish;
  end

  initial begin
    #100000;
    failures++;
    tally_and_finish;
  end
endmodule : tb
